// >>> rtl/gq_pkg.sv
// constants, types and helpers for the pin level and configuration query
package gq_pkg;
   // packet codes and lengths
   localparam logic [7:0] PT_QUERY     = 8'h23;
   localparam logic [7:0] PT_REPLY_BIT = 8'h40;
   localparam logic [7:0] PT_REPLY     = PT_QUERY | PT_REPLY_BIT;
   localparam logic [7:0] PT_ERR_BITS  = 8'hc0;
   localparam logic [7:0] PT_ERROR     = PT_QUERY | PT_ERR_BITS;
   localparam logic [7:0] QUERY_LEN    = 8'h01;
   localparam logic [7:0] REPLY_LEN    = 8'h04;
   localparam logic [7:0] ERROR_LEN    = 8'h00;

   // pin population
   localparam int         N_GPIO = 5;
   localparam int         N_PIN  = 13;
   localparam logic [7:0] LAST_GPIO_SEL = 8'h04;
   localparam logic [7:0] LAST_PIN_SEL  = 8'h0c;

   // field positions in the status and config bytes
   localparam int LEVEL_BIT = 0;
   localparam int FALL_BIT  = 1;
   localparam int RISE_BIT  = 2;
   localparam int FUNC_BIT  = 3;

   // duty range
   localparam logic [7:0] DUTY_MAX = 8'h64;

   // values after reset
   localparam logic [7:0] RST_DUTY  = 8'h00;
   localparam logic       RST_FUNC  = 1'b0;
   localparam logic [2:0] RST_DRIVE = 3'b010;

   // timing
   localparam longint CLK_HZ        = 125000000;
   localparam longint SAMPLE_HZ     = 32;
   localparam longint PWM_HZ        = 100;
   localparam int     SAMPLE_DIV    = int'(CLK_HZ / SAMPLE_HZ);
   localparam int     PWM_STEP_DIV  = int'(CLK_HZ / (PWM_HZ * 100));

   typedef enum logic [2:0] {
      DRV_FAST_UP_RES_DN  = 3'b000,
      DRV_FAST_BOTH       = 3'b001,
      DRV_HIZ_INPUT       = 3'b010,
      DRV_RES_UP_FAST_DN  = 3'b011,
      DRV_SLOW_UP_HIZ_DN  = 3'b100,
      DRV_SLOW_BOTH       = 3'b101,
      DRV_RESERVED        = 3'b110,
      DRV_HIZ_UP_SLOW_DN  = 3'b111
   } gq_drive_mode_t;

   typedef struct packed {
      logic [7:0] ptype;
      logic [7:0] plen;
      logic [7:0] data;
   } gq_req_t;

   typedef struct packed {
      logic [7:0] ptype;
      logic [7:0] plen;
      logic [7:0] b0;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
   } gq_reply_t;

   typedef struct packed {
      logic [7:0]     duty;
      logic           func;
      gq_drive_mode_t drive;
   } gq_cfg_t;

   function automatic logic is_gpio(input logic [7:0] sel);
      return sel <= LAST_GPIO_SEL;
   endfunction

   function automatic logic is_pin(input logic [7:0] sel);
      return sel <= LAST_PIN_SEL;
   endfunction
endpackage

// >>> rtl/gq_pin_sampler.sv
// synchroniser, slow sampler and sticky edge flags for the two-way pins
module gq_pin_sampler
   import gq_pkg::*;
#(
   parameter int NPIN = N_GPIO
)
(
   // clock and reset
   input  wire logic            mclk,
   input  wire logic            rst,
   // sample tick and sensed pad levels
   input  wire logic            sample_en,
   input  wire logic [NPIN-1:0] pin_in,
   // flag restart from the query side
   input  wire logic            clear_en,
   input  wire logic [NPIN-1:0] clear_mask,
   // sampled state
   output logic      [NPIN-1:0] level,
   output logic      [NPIN-1:0] fall,
   output logic      [NPIN-1:0] rise
);
   logic [NPIN-1:0] sync_a;
   logic [NPIN-1:0] sync_b;
   logic [NPIN-1:0] next_sync_a;
   logic [NPIN-1:0] next_sync_b;
   logic [NPIN-1:0] next_level;
   logic [NPIN-1:0] next_fall;
   logic [NPIN-1:0] next_rise;
   logic            primed;
   logic            next_primed;

   always_comb
   begin
      next_sync_a = pin_in;                           // RULE_17
      next_sync_b = sync_a;                           // RULE_17
      // first tick only loads the level; a pin resting high
      // would otherwise show a false rising edge after reset
      next_primed = primed | sample_en;
   end

   genvar i;
   generate
      for (i = 0; i < NPIN; i++)
      begin : g_pin
         logic clr;
         assign clr = clear_en & clear_mask[i];
         always_comb
         begin
            // sensed pad voltage, not the commanded output
            next_level[i] = sample_en ? sync_b[i] : level[i]; // RULE_09 RULE_10
            next_fall[i]  = clr ? 1'b0 : fall[i];
            next_rise[i]  = clr ? 1'b0 : rise[i];
            // a sampled edge beats a clear in the same cycle
            if (sample_en && primed && level[i] && !sync_b[i])
            begin
               next_fall[i] = 1'b1;                   // RULE_06
            end
            if (sample_en && primed && !level[i] && sync_b[i])
            begin
               next_rise[i] = 1'b1;                   // RULE_07
            end
         end

         chk_fall_set: assert property (              // RULE_06
            @(posedge mclk) disable iff (rst)
            sample_en && primed && level[i] && !sync_b[i] |=> fall[i])
            else $error("falling sample did not set flag");
         chk_rise_set: assert property (              // RULE_07
            @(posedge mclk) disable iff (rst)
            sample_en && primed && !level[i] && sync_b[i] |=> rise[i])
            else $error("rising sample did not set flag");
      end
   endgenerate

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sync_a <= '0;
         primed <= 1'b0;
         sync_b <= '0;
         level  <= '0;
         fall   <= '0;
         rise   <= '0;
      end
      else
      begin
         sync_a <= next_sync_a;
         primed <= next_primed;
         sync_b <= next_sync_b;
         level  <= next_level;
         fall   <= next_fall;
         rise   <= next_rise;
      end
   end

   chk_level_hold: assert property (                  // RULE_09
      @(posedge mclk) disable iff (rst)
      !sample_en |=> $stable(level))
      else $error("level moved between samples");
   chk_sync_delay: assert property (                  // RULE_17
      @(posedge mclk) disable iff (rst)
      sample_en |=> level == $past(pin_in, 3))
      else $error("level not taken through two stages");
endmodule // gq_pin_sampler

// >>> rtl/gq_query.sv
// pin level and configuration query handler with duty waveform generator
// Overview of operation
// RULE_01: a query packet has type 0x23 and one payload byte naming the pin.
// RULE_02: selectors 0-4 are two-way pins, 5-12 output-only, 13-255 reserved.
// RULE_03: the reply has type 0x63 (request type with bit 6 set), 4 bytes.
// RULE_04: reply byte 0 echoes the selector from the request.
// RULE_05: reply byte 1 bit 0 is the level taken at the last sample.
// RULE_06: byte 1 bit 1 flags a falling edge since the last query of the pin.
// RULE_07: byte 1 bit 2 flags a rising edge since the last query of the pin.
// RULE_08: for output-only pins byte 1 is zero.
// RULE_09: pins are sampled at about 32 Hz, apart from query arrival.
// RULE_10: the level reported is the sensed pad, not the commanded output.
// RULE_11: reply byte 2 is the stored duty setting, 0 to 100.
// RULE_12: reply byte 3 holds function in bit 3, drive mode in bits 2-0.
// RULE_13: drive codes follow the documented eight modes, 110 reserved.
// RULE_14: function reads 1 for user control, 0 otherwise, 0 for outputs.
// RULE_15: duty 1-99 gives a 100 Hz pulse train, 0 steady low, 100 high.
// RULE_16: a reserved selector alters nothing and gets an error reply.
// RULE_17: every sampled pin passes two flip-flops before edge detection.
module gq_query
   import gq_pkg::*;
#(
   parameter int SAMPLE_CYCLES   = SAMPLE_DIV,
   parameter int PWM_STEP_CYCLES = PWM_STEP_DIV
)
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // query request
   input  wire logic                  req_valid,
   output logic                       req_ready,
   input  wire gq_req_t               req,
   // reply
   output logic                       rsp_valid,
   input  wire logic                  rsp_ready,
   output gq_reply_t                  rsp,
   // configuration writes from the set command
   input  wire logic                  cfg_we,
   input  wire logic [7:0]            cfg_sel,
   input  wire gq_cfg_t               cfg_wdata,
   // pads
   input  wire logic [N_GPIO-1:0]     pin_in,
   output logic      [N_PIN-1:0]      pwm_out,
   output logic      [N_PIN-1:0][2:0] drive_mode,
   output logic      [N_GPIO-1:0]     func_sel
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01
   } gq_state_t;

   gq_state_t        state;
   gq_state_t        next_state;
   gq_reply_t        rsp_q;
   gq_reply_t        next_rsp;
   gq_cfg_t          cfg   [N_PIN];
   gq_cfg_t          next_cfg [N_PIN];
   logic [31:0]      samp_cnt;
   logic [31:0]      next_samp_cnt;
   logic [31:0]      step_cnt;
   logic [31:0]      next_step_cnt;
   logic [7:0]       phase;
   logic [7:0]       next_phase;
   logic [N_PIN-1:0] next_pwm;
   logic             sample_en;
   logic             step_en;
   logic             take;
   logic             good_query;
   logic             clear_en;
   logic [N_GPIO-1:0] clear_mask;
   logic [N_GPIO-1:0] level;
   logic [N_GPIO-1:0] fall;
   logic [N_GPIO-1:0] rise;
   logic [3:0]       sel4;

   assign req_ready  = (state == ST_IDLE);
   assign rsp_valid  = (state == ST_SEND);
   assign rsp        = rsp_q;
   assign take       = req_valid && req_ready && req.ptype == PT_QUERY;
   assign good_query = req.plen == QUERY_LEN && is_pin(req.data); // RULE_01 RULE_02
   assign sel4       = req.data[3:0];
   // reserved selectors and malformed queries leave the flags alone
   assign clear_en   = take && good_query && is_gpio(req.data); // RULE_16

   always_comb
   begin
      clear_mask = '0;
      for (int k = 0; k < N_GPIO; k++)
      begin
         clear_mask[k] = (sel4 == 4'(k));             // RULE_06 RULE_07
      end
   end

   gq_pin_sampler #(
      .NPIN       (N_GPIO)
   ) u_sampler (
      .mclk       (mclk),
      .rst        (rst),
      .sample_en  (sample_en),
      .pin_in     (pin_in),
      .clear_en   (clear_en),
      .clear_mask (clear_mask),
      .level      (level),
      .fall       (fall),
      .rise       (rise)
   );

   // query handling
   always_comb
   begin
      next_state = state;
      next_rsp   = rsp_q;
      if (state == ST_IDLE && take)
      begin
         next_state = ST_SEND;
         if (good_query)
         begin
            next_rsp.ptype = PT_REPLY;                // RULE_03
            next_rsp.plen  = REPLY_LEN;               // RULE_03
            next_rsp.b0    = req.data;                // RULE_04
            next_rsp.b1    = '0;                      // RULE_08
            next_rsp.b3    = '0;
            next_rsp.b2    = cfg[sel4].duty;          // RULE_11
            next_rsp.b3[2:0] = cfg[sel4].drive;       // RULE_12 RULE_13
            if (is_gpio(req.data))
            begin
               next_rsp.b1[LEVEL_BIT] = level[sel4[2:0]]; // RULE_05 RULE_10
               next_rsp.b1[FALL_BIT]  = fall[sel4[2:0]];  // RULE_06
               next_rsp.b1[RISE_BIT]  = rise[sel4[2:0]];  // RULE_07
               next_rsp.b3[FUNC_BIT]  = cfg[sel4].func;   // RULE_14
            end
         end
         else
         begin
            next_rsp       = '0;
            next_rsp.ptype = PT_ERROR;                // RULE_16
            next_rsp.plen  = ERROR_LEN;
            next_rsp.b0    = req.data;
         end
      end
      else if (state == ST_SEND && rsp_ready)
      begin
         next_state = ST_IDLE;
      end
   end

   // stored settings; output-only pins never keep a function bit
   always_comb
   begin
      for (int k = 0; k < N_PIN; k++)
      begin
         next_cfg[k] = cfg[k];
         if (cfg_we && cfg_sel == 8'(k) && cfg_wdata.duty <= DUTY_MAX)
         begin
            next_cfg[k] = cfg_wdata;
            next_cfg[k].func = (k < N_GPIO) ? cfg_wdata.func : 1'b0; // RULE_14
         end
      end
   end

   // slow tick dividers and duty waveform
   always_comb
   begin
      sample_en     = (samp_cnt == 32'(SAMPLE_CYCLES - 1)); // RULE_09
      next_samp_cnt = sample_en ? '0 : samp_cnt + 32'h1;
      step_en       = (step_cnt == 32'(PWM_STEP_CYCLES - 1));
      next_step_cnt = step_en ? '0 : step_cnt + 32'h1;
      next_phase    = phase;
      if (step_en)
      begin
         next_phase = (phase == DUTY_MAX - 8'h01) ? 8'h00 : phase + 8'h01;
      end
      for (int k = 0; k < N_PIN; k++)
      begin
         // 100 steps a period; 0 never high, 100 always high
         next_pwm[k] = (phase < cfg[k].duty);         // RULE_15
      end
   end

   always_comb
   begin
      for (int k = 0; k < N_PIN; k++)
      begin
         drive_mode[k] = cfg[k].drive;
      end
      for (int k = 0; k < N_GPIO; k++)
      begin
         func_sel[k] = cfg[k].func;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state    <= ST_IDLE;
         rsp_q    <= '0;
         samp_cnt <= '0;
         step_cnt <= '0;
         phase    <= '0;
         pwm_out  <= '0;
         for (int k = 0; k < N_PIN; k++)
         begin
            cfg[k] <= '{RST_DUTY, RST_FUNC, gq_drive_mode_t'(RST_DRIVE)};
         end
      end
      else
      begin
         state    <= next_state;
         rsp_q    <= next_rsp;
         samp_cnt <= next_samp_cnt;
         step_cnt <= next_step_cnt;
         phase    <= next_phase;
         pwm_out  <= next_pwm;
         for (int k = 0; k < N_PIN; k++)
         begin
            cfg[k] <= next_cfg[k];
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_good_take;
      take && good_query;
   endsequence
   sequence s_bad_take;
      take && !good_query;
   endsequence

   chk_reply_type: assert property (                  // RULE_03
      s_good_take |=>
      rsp_valid && rsp.ptype == 8'h63 && rsp.plen == 8'h04)
      else $error("reply type or length wrong");
   chk_echo_index: assert property (                  // RULE_04
      s_good_take |=> rsp.b0 == $past(req.data))
      else $error("selector not echoed");
   chk_gpo_status: assert property (                  // RULE_08
      s_good_take ##0 !is_gpio(req.data) |=>
      rsp.b1 == 8'h00 && !rsp.b3[3])
      else $error("output-only pin shows status or function");
   chk_cfg_upper: assert property (                   // RULE_12
      rsp_valid && rsp.ptype == PT_REPLY |-> rsp.b3[7:4] == 4'h0)
      else $error("config byte upper bits set");
   chk_duty_echo: assert property (                   // RULE_11
      s_good_take ##0 (sel4 == 4'h5) |=>
      rsp.b2 == $past(cfg[5].duty))
      else $error("duty not reported");
   chk_level_echo: assert property (                  // RULE_05
      s_good_take ##0 (sel4 == 4'h0) |=>
      rsp.b1[0] == $past(level[0]))
      else $error("level not reported");
   // the whole error reply, not only its type
   chk_reserved_err: assert property (                // RULE_16
      s_bad_take |=> rsp_valid && rsp.ptype == PT_ERROR &&
      rsp.plen == ERROR_LEN && rsp.b0 == $past(req.data) &&
      rsp[23:0] == 24'h0)
      else $error("reserved selector did not get error reply");
   // only a sample tick may move the flags across a refused query
   chk_no_clear_bad: assert property (                // RULE_16
      s_bad_take ##0 !sample_en |=> $stable(fall) && $stable(rise))
      else $error("reserved selector cleared flags");
   chk_pwm_low: assert property (                     // RULE_15
      cfg[0].duty == 8'h00 && $past(cfg[0].duty) == 8'h00 |-> !pwm_out[0])
      else $error("zero duty drove high");
   chk_pwm_high: assert property (                    // RULE_15
      cfg[0].duty == 8'h64 && $past(cfg[0].duty) == 8'h64 |-> pwm_out[0])
      else $error("full duty drove low");
   chk_sample_gap: assert property (sample_en |=> !sample_en [*2]) // RULE_09
      else $error("sample ticks too close");
endmodule // gq_query

// >>> bench/gq_host_model.sv
// host side model: sends query packets and accepts the replies
module gq_host_model
   import gq_pkg::*;
(
   // clock
   input  wire logic      mclk,
   // request side
   output logic           req_valid,
   input  wire logic      req_ready,
   output gq_req_t        req,
   // reply side
   input  wire logic      rsp_valid,
   output logic           rsp_ready,
   input  wire gq_reply_t rsp
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      req_valid = 1'b0;
      req       = '0;
      rsp_ready = 1'b0;
   end

   // one query; ok stays low when no reply comes back
   task automatic xfer(input gq_req_t r, input int stall,
                       output gq_reply_t got, output bit ok);
      int n;
      ok  = 1'b0;
      got = '0;
      n   = 0;
      @(negedge mclk);
      req_valid = 1'b1;
      req       = r;
      while (!rsp_valid && n < 12)
      begin
         @(negedge mclk);
         n++;
      end
      // released lines carry junk so a stale copy cannot pass
      req_valid = 1'b0;
      req       = ~r;
      if (rsp_valid)
      begin
         repeat (stall) @(negedge mclk);
         got       = rsp;
         ok        = rsp_valid;
         rsp_ready = 1'b1;
         @(negedge mclk);
         rsp_ready = 1'b0;
      end
   endtask
endmodule // gq_host_model

// >>> bench/test_gq_query.sv
// self-checking bench for the pin level and configuration query
module test_gq_query
   import gq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SCYC = 8;
   localparam int PCYC = 2;

   logic                  mclk, rst, req_valid, req_ready;
   logic                  rsp_valid, rsp_ready, cfg_we;
   gq_req_t               req;
   gq_reply_t             rsp;
   logic [7:0]            cfg_sel;
   gq_cfg_t               cfg_wdata;
   logic [N_GPIO-1:0]     pin_in, func_sel;
   logic [N_PIN-1:0]      pwm_out;
   logic [N_PIN-1:0][2:0] drive_mode;
   int                    miscompares, compares;

   gq_query #(.SAMPLE_CYCLES(SCYC), .PWM_STEP_CYCLES(PCYC)) dut (
      .mclk(mclk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp(rsp), .cfg_we(cfg_we),
      .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata), .pin_in(pin_in),
      .pwm_out(pwm_out), .drive_mode(drive_mode), .func_sel(func_sel));

   gq_host_model host (
      .mclk(mclk), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
      .rsp(rsp));

   always #4 mclk = ~mclk;

   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one query; tail is reply bytes 1..3, err expects the error reply
   task automatic q(input logic [7:0] pl, sel, input logic [23:0] tail,
                    input bit err, input int stall);
      gq_reply_t got;
      bit        ok;
      host.xfer('{PT_QUERY, pl, sel}, stall, got, ok);
      chk(48'(ok), 48'h1);
      chk(got, err ? {PT_ERROR, ERROR_LEN, sel, 24'h0}
                   : {PT_REPLY, REPLY_LEN, sel, tail});
      chk(48'(req_ready), 48'h1);
   endtask

   task automatic cfg(input logic [7:0] sel, duty, input logic f,
                      input logic [2:0] d);
      @(negedge mclk);
      cfg_we    = 1'b1;
      cfg_sel   = sel;
      cfg_wdata = '{duty, f, gq_drive_mode_t'(d)};
      @(negedge mclk);
      cfg_we    = 1'b0;
      cfg_sel   = ~sel;
      @(negedge mclk);
   endtask

   task automatic settle();
      repeat (3 * SCYC + 4) @(negedge mclk);
   endtask

   task automatic t_reset();
      chk(48'(drive_mode), 48'({N_PIN{3'b010}}));
      chk(48'(func_sel), 48'h0);
      chk(48'(pwm_out), 48'h0);
      for (int s = 0; s < N_PIN; s++)
         q(8'h01, 8'(s), 24'h000002, 1'b0, 0);
   endtask

   task automatic t_levels();
      pin_in = 5'b10101;
      settle();
      for (int s = 0; s < N_PIN; s++)
         q(8'h01, 8'(s), {(s < 5 && pin_in[s]) ? 8'h05 : 8'h00,
           16'h0002}, 1'b0, 0);
      q(8'h01, 8'h00, 24'h010002, 1'b0, 0);
      pin_in = 5'b00000;
      settle();
      q(8'h01, 8'h00, 24'h020002, 1'b0, 0);
      q(8'h01, 8'h01, 24'h000002, 1'b0, 0);
   endtask

   task automatic t_config();
      cfg(8'h03, 8'h32, 1'b1, 3'b101);
      chk(48'(drive_mode[3]), 48'h5);
      chk(48'(func_sel[3]), 48'h1);
      q(8'h01, 8'h03, 24'h00320d, 1'b0, 0);
      cfg(8'h07, 8'h64, 1'b1, 3'b001);
      q(8'h01, 8'h07, 24'h006401, 1'b0, 0);
      // out-of-range duty is dropped together with its mode bits
      cfg(8'h03, 8'h65, 1'b0, 3'b000);
      q(8'h01, 8'h03, 24'h00320d, 1'b0, 0);
      for (int d = 0; d < 8; d++)
      begin
         cfg(8'h01, 8'h00, 1'b0, 3'(d));
         chk(48'(drive_mode[1]), 48'(d));
         q(8'h01, 8'h01, {16'h0, 8'(d)}, 1'b0, 0);
      end
   endtask

   task automatic t_pwm();
      int hi0, hi7, hi2;
      hi0 = 0;
      hi7 = 0;
      hi2 = 0;
      cfg(8'h00, 8'h32, 1'b1, 3'b001);
      // any 200-cycle span holds one whole period
      repeat (100 * PCYC)
      begin
         @(negedge mclk);
         hi0 += int'(pwm_out[0]);
         hi7 += int'(pwm_out[7]);
         hi2 += int'(pwm_out[2]);
      end
      chk(48'(hi0), 48'd100);
      chk(48'(hi7), 48'd200);
      chk(48'(hi2), 48'd0);
      q(8'h01, 8'h00, 24'h003209, 1'b0, 0);
   endtask

   task automatic t_errors();
      gq_reply_t got;
      bit        ok;
      pin_in = 5'b00100;
      settle();
      q(8'h01, 8'h0d, 24'h0, 1'b1, 0);
      q(8'h01, 8'hff, 24'h0, 1'b1, 0);
      q(8'h02, 8'h02, 24'h0, 1'b1, 0);
      host.xfer('{8'h22, 8'h01, 8'h02}, 0, got, ok);
      chk(48'(ok), 48'h0);
      chk(48'(req_ready), 48'h1);
      // fall from the earlier low phase and the new rise both survive
      q(8'h01, 8'h02, 24'h070002, 1'b0, 0);
      q(8'h01, 8'h02, 24'h010002, 1'b0, 5);
   endtask

   initial
   begin
      mclk        = 1'b0;
      rst         = 1'b1;
      cfg_we      = 1'b0;
      cfg_sel     = '0;
      cfg_wdata   = '0;
      pin_in      = '0;
      miscompares = 0;
      compares    = 0;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      t_reset();
      t_levels();
      t_config();
      t_pwm();
      t_errors();
      give_verdict();
   end

   initial
   begin
      repeat (6000) @(posedge mclk);
      miscompares++;
      $display("ERROR at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule // test_gq_query
